// file: rtl/txctl_pkg.sv
`default_nettype none
package txctl_pkg;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 4;
  localparam int REG_BITS = 16;
  localparam logic [3:0] ADDR_OP_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_CONFIGURATION = 4'h5;
  localparam logic [15:0] OP_CONTROL_RESET = 16'h892f;
  localparam logic [15:0] CONFIGURATION_RESET = 16'hd03f;
  // op_control fields
  localparam int OP_LO_PORT_SELECT = 15;
  localparam int OP_RF_HOLD = 14;
  localparam int OP_IF_HOLD = 13;
  localparam int OP_MODE_HI = 12;
  localparam int OP_MODE_LO = 11;
  localparam int OP_IF_PORT = 10;
  localparam int OP_IF_OSC = 9;
  localparam int OP_GAIN_HI = 8;
  localparam int OP_GAIN_LO = 6;
  localparam int OP_SIDEBAND = 5;
  localparam int OP_LO_BUF = 4;
  localparam int OP_MOD_SEL = 3;
  localparam int OP_KEEP_REGS_N = 2;
  localparam int OP_TX_SLEEP_N = 1;
  localparam int OP_SOFT_OFF_N = 0;
  // configuration fields
  localparam int CF_IF_SYNTH_N = 15;
  localparam int CF_RF_SYNTH_N = 14;
  localparam int CF_SWING = 12;
  localparam int CF_HALVE = 11;
  localparam int CF_EXT_OSC = 10;
  localparam int CF_IF_PUMP_HI = 9;
  localparam int CF_IF_PUMP_LO = 8;
  localparam int CF_RF_PUMP_HI = 7;
  localparam int CF_RF_PUMP_LO = 6;
  localparam int CF_IF_POL = 5;
  localparam int CF_RF_POL = 4;
  localparam int CF_IF_FAST = 3;
  localparam int CF_RF_FAST = 2;
  localparam int CF_LOCK_HI = 1;
  localparam int CF_LOCK_LO = 0;
  localparam int FAST_REVERSALS = 2;
  typedef enum logic [1:0] {
    MODE_FM = 2'b00,
    MODE_CELL = 2'b01,
    MODE_PCS_UPPER = 2'b10,
    MODE_PCS_LOWER = 2'b11
  } band_mode_e;
  typedef enum logic [1:0] {
    LOCK_TEST = 2'b00,
    LOCK_IF = 2'b01,
    LOCK_RF = 2'b10,
    LOCK_BOTH = 2'b11
  } lock_sel_e;
endpackage : txctl_pkg
`default_nettype wire

// file: rtl/fast_acquire_ctl.sv
`default_nettype none
module fast_acquire_ctl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic hold_in,
  input wire logic restart_in,
  input wire logic lead_in,
  input wire logic acquired_in,
  output logic boost_out
);
  import txctl_pkg::*;
  logic [1:0] rev_reg;
  logic lead_prev_reg;
  logic active_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lead_prev_reg <= 1'b0;
    end else begin
      lead_prev_reg <= lead_in;
    end
  end
  // boost ends after second lead/lag reversal or on acquisition
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rev_reg <= 2'b00;
      active_reg <= 1'b1;
    end else if (restart_in) begin
      rev_reg <= 2'b00;
      active_reg <= 1'b1;
    end else if (active_reg) begin
      if (acquired_in) begin
        active_reg <= 1'b0;
      end else if (lead_in != lead_prev_reg) begin
        if (rev_reg == 2'(FAST_REVERSALS - 1)) begin
          active_reg <= 1'b0;
        end
        rev_reg <= rev_reg + 2'b01;
      end
    end
  end
  // hold keeps boost after acquisition, only while fast acquire enabled
  assign boost_out = enable_in & (active_reg | hold_in);
endmodule : fast_acquire_ctl
`default_nettype wire

// file: rtl/transmitter_control_registers.sv
`default_nettype none
module transmitter_control_registers (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic chip_select_n_in,
  input wire logic tx_gate_pin_n_in,
  input wire logic if_lock_in,
  input wire logic rf_lock_in,
  input wire logic if_lead_in,
  input wire logic rf_lead_in,
  output logic [15:0] op_control_out,
  output logic [15:0] configuration_out,
  output logic lo_low_port_en_out,
  output logic lo_high_port_en_out,
  output logic pa_cell_out,
  output logic pa_pcs_upper_out,
  output logic pa_pcs_lower_out,
  output logic fm_mode_out,
  output logic if_high_ports_en_out,
  output logic if_low_ports_en_out,
  output logic if_osc_high_en_out,
  output logic if_osc_low_en_out,
  output logic [2:0] if_gain_step_out,
  output logic upper_sideband_out,
  output logic lo_copy_out_en_out,
  output logic lo_copy_halve_out,
  output logic quad_mod_en_out,
  output logic ext_mod_en_out,
  output logic core_power_en_out,
  output logic tx_path_en_out,
  output logic if_pll_en_out,
  output logic rf_pll_en_out,
  output logic swing_200mv_out,
  output logic ext_osc_buffer_en_out,
  output logic internal_if_osc_en_out,
  output logic [1:0] if_pump_level_out,
  output logic [1:0] rf_pump_level_out,
  output logic if_detector_positive_out,
  output logic rf_detector_positive_out,
  output logic if_pump_boost_out,
  output logic rf_pump_boost_out,
  output logic lock_indicator_out
);
  import txctl_pkg::*;
  logic [1:0] sclk_sync_reg;
  logic [1:0] sdat_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] gate_sync_reg;
  logic [1:0] iflk_sync_reg;
  logic [1:0] rflk_sync_reg;
  logic [1:0] iflead_sync_reg;
  logic [1:0] rflead_sync_reg;
  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [15:0] op_reg;
  logic [15:0] cfg_reg;
  logic sclk_rise;
  logic cs_rise;
  logic [3:0] frame_addr;
  logic [15:0] frame_data;
  logic soft_off;
  logic awake;
  logic tx_gate_n;
  logic if_boost_raw;
  logic rf_boost_raw;
  logic if_restart;
  logic rf_restart;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_sync_reg <= 2'b00;
      sdat_sync_reg <= 2'b00;
      cs_sync_reg <= 2'b11;
      gate_sync_reg <= 2'b11;
      iflk_sync_reg <= 2'b00;
      rflk_sync_reg <= 2'b00;
      iflead_sync_reg <= 2'b00;
      rflead_sync_reg <= 2'b00;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], ser_clk_in};
      sdat_sync_reg <= {sdat_sync_reg[0], ser_data_in};
      cs_sync_reg <= {cs_sync_reg[0], chip_select_n_in};
      gate_sync_reg <= {gate_sync_reg[0], tx_gate_pin_n_in};
      iflk_sync_reg <= {iflk_sync_reg[0], if_lock_in};
      rflk_sync_reg <= {rflk_sync_reg[0], rf_lock_in};
      iflead_sync_reg <= {iflead_sync_reg[0], if_lead_in};
      rflead_sync_reg <= {rflead_sync_reg[0], rf_lead_in};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign cs_rise = cs_sync_reg[1] & ~cs_prev_reg;
  assign frame_addr = shift_reg[ADDR_BITS-1:0];
  // bits 23..20 of the frame are don't-care
  assign frame_data = shift_reg[ADDR_BITS+REG_BITS-1:ADDR_BITS];

  // serial shifter keeps running even in soft power off
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= '0;
    end else if (!cs_sync_reg[1] && sclk_rise) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], sdat_sync_reg[1]};
    end
  end

  assign soft_off = ~op_reg[OP_SOFT_OFF_N];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_reg <= OP_CONTROL_RESET;
      cfg_reg <= CONFIGURATION_RESET;
    end else if (cs_rise && frame_addr == ADDR_OP_CONTROL) begin
      op_reg <= frame_data;
    end else if (cs_rise && frame_addr == ADDR_CONFIGURATION) begin
      cfg_reg <= frame_data;
    end else if (soft_off) begin
      // registers return to power-up values; bus stays live
      op_reg <= OP_CONTROL_RESET;
      cfg_reg <= CONFIGURATION_RESET;
    end
  end

  assign op_control_out = op_reg;
  assign configuration_out = cfg_reg;

  // soft off, standby both clear awake; gain, sideband, halve, swing, pump level, polarity and lock outputs stay live
  assign awake = op_reg[OP_KEEP_REGS_N] & ~soft_off;
  assign tx_gate_n = gate_sync_reg[1];

  always_comb begin
    pa_cell_out = 1'b0;
    pa_pcs_upper_out = 1'b0;
    pa_pcs_lower_out = 1'b0;
    fm_mode_out = 1'b0;
    unique case (band_mode_e'(op_reg[OP_MODE_HI:OP_MODE_LO]))
      MODE_FM: begin
        fm_mode_out = awake;
        pa_cell_out = tx_path_en_out;
      end
      MODE_CELL: pa_cell_out = tx_path_en_out;
      MODE_PCS_UPPER: pa_pcs_upper_out = tx_path_en_out;
      MODE_PCS_LOWER: pa_pcs_lower_out = tx_path_en_out;
    endcase
  end

  assign lo_low_port_en_out = awake & op_reg[OP_LO_PORT_SELECT];
  assign lo_high_port_en_out = awake & ~op_reg[OP_LO_PORT_SELECT];
  // host keeps this bit clear in FM mode
  assign if_high_ports_en_out = awake & op_reg[OP_IF_PORT];
  assign if_low_ports_en_out = awake & ~op_reg[OP_IF_PORT];
  assign internal_if_osc_en_out = awake & ~cfg_reg[CF_EXT_OSC];
  assign ext_osc_buffer_en_out = awake & cfg_reg[CF_EXT_OSC];
  assign if_osc_high_en_out = internal_if_osc_en_out
                              & op_reg[OP_IF_OSC];
  assign if_osc_low_en_out = internal_if_osc_en_out
                             & ~op_reg[OP_IF_OSC];
  assign if_gain_step_out = op_reg[OP_GAIN_HI:OP_GAIN_LO];
  assign upper_sideband_out = op_reg[OP_SIDEBAND];
  assign lo_copy_out_en_out = awake & op_reg[OP_LO_BUF];
  assign lo_copy_halve_out = cfg_reg[CF_HALVE];
  assign quad_mod_en_out = tx_path_en_out & op_reg[OP_MOD_SEL];
  assign ext_mod_en_out = tx_path_en_out & ~op_reg[OP_MOD_SEL];
  assign core_power_en_out = awake;
  // software sleep and the gate pin act alike
  assign tx_path_en_out = awake & op_reg[OP_TX_SLEEP_N]
                          & tx_gate_n;
  assign if_pll_en_out = awake & cfg_reg[CF_IF_SYNTH_N];
  assign rf_pll_en_out = awake & cfg_reg[CF_RF_SYNTH_N];
  assign swing_200mv_out = cfg_reg[CF_SWING];
  assign if_pump_level_out = cfg_reg[CF_IF_PUMP_HI:CF_IF_PUMP_LO];
  assign rf_pump_level_out = cfg_reg[CF_RF_PUMP_HI:CF_RF_PUMP_LO];
  assign if_detector_positive_out = cfg_reg[CF_IF_POL];
  assign rf_detector_positive_out = cfg_reg[CF_RF_POL];

  // acquisition restarts when the PLL is off or its config is rewritten
  assign if_restart = ~if_pll_en_out
                      | (cs_rise && frame_addr == ADDR_CONFIGURATION);
  assign rf_restart = ~rf_pll_en_out
                      | (cs_rise && frame_addr == ADDR_CONFIGURATION);

  fast_acquire_ctl u_if_fast (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(cfg_reg[CF_IF_FAST]),
    .hold_in(op_reg[OP_IF_HOLD]),
    .restart_in(if_restart),
    .lead_in(iflead_sync_reg[1]),
    .acquired_in(iflk_sync_reg[1]),
    .boost_out(if_boost_raw)
  );

  fast_acquire_ctl u_rf_fast (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .enable_in(cfg_reg[CF_RF_FAST]),
    .hold_in(op_reg[OP_RF_HOLD]),
    .restart_in(rf_restart),
    .lead_in(rflead_sync_reg[1]),
    .acquired_in(rflk_sync_reg[1]),
    .boost_out(rf_boost_raw)
  );

  assign if_pump_boost_out = if_pll_en_out & if_boost_raw;
  assign rf_pump_boost_out = rf_pll_en_out & rf_boost_raw;

  always_comb begin
    lock_indicator_out = 1'b0;
    unique case (lock_sel_e'(cfg_reg[CF_LOCK_HI:CF_LOCK_LO]))
      LOCK_TEST: lock_indicator_out = 1'b0;
      LOCK_IF: lock_indicator_out = iflk_sync_reg[1];
      LOCK_RF: lock_indicator_out = rflk_sync_reg[1];
      LOCK_BOTH: lock_indicator_out = iflk_sync_reg[1] & rflk_sync_reg[1];
    endcase
  end

  // assertions
  a_load_op_reg: assert property (@(posedge clk_in) disable iff (rst_in)
    cs_rise && frame_addr == ADDR_OP_CONTROL
    |=> op_reg == $past(frame_data))
    else $error("op_control not loaded on chip select rise");
  a_load_cfg_reg: assert property (@(posedge clk_in) disable iff (rst_in)
    cs_rise && frame_addr == ADDR_CONFIGURATION
    |=> cfg_reg == $past(frame_data))
    else $error("configuration not loaded on chip select rise");
  a_shift_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    cs_sync_reg[1] |=> shift_reg == $past(shift_reg))
    else $error("shift register moved with chip select high");
  a_shift_bit: assert property (@(posedge clk_in) disable iff (rst_in)
    !cs_sync_reg[1] && sclk_rise
    |=> shift_reg[0] == $past(sdat_sync_reg[1]))
    else $error("serial bit not captured");
  a_soft_off_rst: assert property (@(posedge clk_in) disable iff (rst_in)
    soft_off && !cs_rise |=> op_reg == OP_CONTROL_RESET
    && cfg_reg == CONFIGURATION_RESET)
    else $error("soft power off did not restore defaults");
  a_standby_off: assert property (@(posedge clk_in) disable iff (rst_in)
    !op_reg[OP_KEEP_REGS_N] |-> !tx_path_en_out && !if_pll_en_out
    && !rf_pll_en_out && !lo_copy_out_en_out)
    else $error("function active in standby");
  a_tx_sleep: assert property (@(posedge clk_in) disable iff (rst_in)
    !op_reg[OP_TX_SLEEP_N] || !tx_gate_n
    |-> !quad_mod_en_out && !ext_mod_en_out)
    else $error("modulator active in tx sleep");
  a_pa_select: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_path_en_out && op_reg[OP_MODE_HI:OP_MODE_LO] == MODE_PCS_UPPER
    |-> pa_pcs_upper_out && !pa_cell_out && !pa_pcs_lower_out)
    else $error("wrong PA output for upper PCS");
  a_lock_route: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_reg[CF_LOCK_HI:CF_LOCK_LO] == LOCK_BOTH
    |-> lock_indicator_out == (iflk_sync_reg[1] & rflk_sync_reg[1]))
    else $error("lock indicator not AND of both");
  a_lo_buffer: assert property (@(posedge clk_in) disable iff (rst_in)
    !op_reg[OP_LO_BUF] |-> !lo_copy_out_en_out)
    else $error("lo copy buffer on with bit clear");
  a_mod_select: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_path_en_out |-> quad_mod_en_out == op_reg[OP_MOD_SEL]
    && ext_mod_en_out == !op_reg[OP_MOD_SEL])
    else $error("modulation select mismatch");
  a_lo_port: assert property (@(posedge clk_in) disable iff (rst_in)
    awake |-> lo_low_port_en_out == op_reg[OP_LO_PORT_SELECT]
    && lo_high_port_en_out != op_reg[OP_LO_PORT_SELECT])
    else $error("LO port select mismatch");
  a_boost_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    !cfg_reg[CF_RF_FAST] |-> !rf_pump_boost_out)
    else $error("RF boost without fast acquire");
endmodule : transmitter_control_registers
`default_nettype wire

// file: test/serial_host_model.sv
`default_nettype none
module serial_host_model (
  input wire logic clk_in,
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic chip_select_n_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    chip_select_n_out = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  // one whole frame; serial clock stands low outside frames
  task automatic send(input logic [23:0] frame);
    step(1);
    chip_select_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      ser_data_out = frame[i];
      step(4);
      ser_clk_out = 1'b1;
      step(4);
      ser_clk_out = 1'b0;
    end
    step(4);
    chip_select_n_out = 1'b1;
    // released data line shows no stale bit
    ser_data_out = ~ser_data_out;
  endtask : send
endmodule : serial_host_model
`default_nettype wire

// file: test/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import txctl_pkg::*;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic tx_gate_pin_n_in = 1'b1;
  logic if_lock_in = 1'b0;
  logic rf_lock_in = 1'b0;
  logic if_lead_in = 1'b0;
  logic rf_lead_in = 1'b0;
  wire logic ser_clk_in, ser_data_in, chip_select_n_in;
  wire logic [15:0] op_control_out, configuration_out;
  wire logic [2:0] if_gain_step_out;
  wire logic [1:0] if_pump_level_out, rf_pump_level_out;
  wire logic lo_low_port_en_out, lo_high_port_en_out, pa_cell_out;
  wire logic pa_pcs_upper_out, pa_pcs_lower_out, fm_mode_out;
  wire logic if_high_ports_en_out, if_low_ports_en_out;
  wire logic if_osc_high_en_out, if_osc_low_en_out, upper_sideband_out;
  wire logic lo_copy_out_en_out, lo_copy_halve_out, quad_mod_en_out;
  wire logic ext_mod_en_out, core_power_en_out, tx_path_en_out;
  wire logic if_pll_en_out, rf_pll_en_out, swing_200mv_out;
  wire logic ext_osc_buffer_en_out, internal_if_osc_en_out;
  wire logic if_detector_positive_out, rf_detector_positive_out;
  wire logic if_pump_boost_out, rf_pump_boost_out, lock_indicator_out;
  int error_cnt = 0;
  int n_checks = 0;

  // decoded outputs gathered for compact comparison
  wire logic [15:0] op_dec = {lo_low_port_en_out, lo_high_port_en_out,
    pa_cell_out, pa_pcs_upper_out, pa_pcs_lower_out, fm_mode_out,
    if_high_ports_en_out, if_low_ports_en_out, if_osc_high_en_out,
    if_osc_low_en_out, if_gain_step_out, upper_sideband_out,
    lo_copy_out_en_out, quad_mod_en_out};
  wire logic [7:0] pwr_dec = {core_power_en_out, tx_path_en_out,
    if_pll_en_out, rf_pll_en_out, ext_mod_en_out, ext_osc_buffer_en_out,
    internal_if_osc_en_out, lo_copy_halve_out};
  wire logic [7:0] cfg_dec = {swing_200mv_out, if_pump_level_out,
    rf_pump_level_out, if_detector_positive_out, rf_detector_positive_out,
    lock_indicator_out};

  transmitter_control_registers dut (
    .clk_in, .rst_in, .ser_clk_in, .ser_data_in, .chip_select_n_in,
    .tx_gate_pin_n_in, .if_lock_in, .rf_lock_in, .if_lead_in, .rf_lead_in,
    .op_control_out, .configuration_out, .lo_low_port_en_out,
    .lo_high_port_en_out, .pa_cell_out, .pa_pcs_upper_out,
    .pa_pcs_lower_out, .fm_mode_out, .if_high_ports_en_out,
    .if_low_ports_en_out, .if_osc_high_en_out, .if_osc_low_en_out,
    .if_gain_step_out, .upper_sideband_out, .lo_copy_out_en_out,
    .lo_copy_halve_out, .quad_mod_en_out, .ext_mod_en_out,
    .core_power_en_out, .tx_path_en_out, .if_pll_en_out, .rf_pll_en_out,
    .swing_200mv_out, .ext_osc_buffer_en_out, .internal_if_osc_en_out,
    .if_pump_level_out, .rf_pump_level_out, .if_detector_positive_out,
    .rf_detector_positive_out, .if_pump_boost_out, .rf_pump_boost_out,
    .lock_indicator_out
  );

  serial_host_model host (
    .clk_in,
    .ser_clk_out(ser_clk_in),
    .ser_data_out(ser_data_in),
    .chip_select_n_out(chip_select_n_in)
  );

  always #10 clk_in = ~clk_in;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // frame nibble above the data is junk on purpose
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    if (a == ADDR_CONFIGURATION) d = d & 16'hdfff;
    host.send({4'ha, d, a});
    cyc(6);
  endtask : wr

  initial begin
    #1500000;
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    cyc(4);
    chk_reg(op_control_out, 16'h892f);
    chk_reg(configuration_out, 16'hd03f);
    chk_reg(op_dec, 16'ha165);
    chk_reg({8'h00, pwr_dec}, 16'h00f2);
    chk_reg({8'h00, cfg_dec}, 16'h0086);
    chk_bit(if_pump_boost_out, 1'b1);
    chk_bit(rf_pump_boost_out, 1'b1);
    repeat (2) begin
      if_lead_in = ~if_lead_in;
      cyc(6);
    end
    chk_bit(if_pump_boost_out, 1'b0);
    chk_bit(rf_pump_boost_out, 1'b1);
    rf_lock_in = 1'b1;
    cyc(6);
    chk_bit(rf_pump_boost_out, 1'b0);
    chk_bit(lock_indicator_out, 1'b0);
    wr(ADDR_OP_CONTROL, 16'ha92f);
    chk_bit(if_pump_boost_out, 1'b1);
    chk_bit(rf_pump_boost_out, 1'b0);
    wr(ADDR_OP_CONTROL, 16'he92f);
    chk_bit(rf_pump_boost_out, 1'b1);
    wr(ADDR_CONFIGURATION, 16'hd033);
    chk_bit(if_pump_boost_out, 1'b0);
    chk_bit(rf_pump_boost_out, 1'b0);
    rf_lock_in = 1'b0;
    wr(ADDR_OP_CONTROL, 16'h7cd7);
    chk_reg(op_control_out, 16'h7cd7);
    chk_reg(op_dec, 16'h4a5a);
    chk_reg({8'h00, pwr_dec}, 16'h00fa);
    wr(ADDR_OP_CONTROL, 16'h832f);
    chk_reg(op_dec, 16'ha5a5);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_OP_CONTROL, 16'h812f | (16'(m) << 11));
      chk_reg({12'h000, op_dec[13:10]},
        {12'h000, m < 2, m == 2, m == 3, m == 0});
    end
    if_lock_in = 1'b1;
    wr(ADDR_CONFIGURATION, 16'h8e59);
    chk_reg(configuration_out, 16'h8e59);
    chk_reg({8'h00, pwr_dec}, 16'h00e5);
    chk_reg({8'h00, cfg_dec}, 16'h004b);
    chk_reg({14'h0, op_dec[7:6]}, 16'h0000);
    chk_bit(rf_pump_boost_out, 1'b0);
    for (int c = 1; c < 4; c++) begin
      wr(ADDR_CONFIGURATION, 16'hd03c | 16'(c));
      for (int k = 0; k < 4; k++) begin
        if_lock_in = k[0];
        rf_lock_in = k[1];
        cyc(4);
        chk_bit(lock_indicator_out,
          (~c[0] | k[0]) & (~c[1] | k[1]));
      end
    end
    wr(ADDR_OP_CONTROL, 16'h892b);
    chk_reg(op_control_out, 16'h892b);
    chk_reg({8'h00, pwr_dec}, 16'h0000);
    wr(ADDR_OP_CONTROL, 16'h892d);
    chk_reg({8'h00, pwr_dec}, 16'h00b2);
    chk_bit(pa_cell_out, 1'b0);
    wr(ADDR_OP_CONTROL, 16'h892f);
    tx_gate_pin_n_in = 1'b0;
    cyc(4);
    chk_reg({8'h00, pwr_dec}, 16'h00b2);
    tx_gate_pin_n_in = 1'b1;
    wr(4'h7, 16'h0000);
    chk_reg(op_control_out, 16'h892f);
    chk_reg(configuration_out, 16'hd03f);
    wr(ADDR_CONFIGURATION, 16'h8e59);
    wr(ADDR_OP_CONTROL, 16'h892e);
    chk_reg(op_control_out, 16'h892f);
    chk_reg(configuration_out, 16'hd03f);
    close_out();
  end
endmodule : testbench
`default_nettype wire
